// ==== logic/acs_pkg.sv ====
// Shared constants and types of the converter sequencer and port configuration block.
// Assumes one 250 MHz system clock that stands for the oscillator.
package acs_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_PORT    = 10'h005;
  localparam logic [9:0] IDX_STAT    = 10'h00C;
  localparam logic [9:0] IDX_RESULT  = 10'h01E;
  localparam logic [9:0] IDX_CTL     = 10'h01F;
  localparam logic [9:0] IDX_CFG     = 10'h09F;

  // ==========================================================
  // Field positions
  localparam int CTL_ON_BIT   = 0;
  localparam int CTL_GO_BIT   = 2;
  localparam int CTL_CHS_LSB  = 3;
  localparam int CTL_CLK_LSB  = 6;
  localparam int STAT_DONE_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTL_RST    = 8'h00;
  localparam logic [2:0] CFG_RST    = 3'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;

  // ==========================================================
  // Timing counts, in half bit periods and system cycles
  localparam logic [3:0] DIV2_LAST     = 4'h0;  // 1 cycle per half period
  localparam logic [3:0] DIV8_LAST     = 4'h3;  // 4 cycles per half period
  localparam logic [3:0] DIV32_LAST    = 4'hF;  // 16 cycles per half period
  localparam logic [4:0] CONV_LAST     = 5'h12; // 19 halves = 9.5 periods
  localparam logic [4:0] DECIDE_LAST   = 5'h0F; // last bit decision half
  localparam logic [1:0] SETTLE_LAST   = 2'h3;  // 4 halves = 2 periods
  localparam logic [1:0] CLK_SEL_RC    = 2'h3;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_OFF    = 4'h1,
    ST_ACQ    = 4'h2,
    ST_CONV   = 4'h4,
    ST_SETTLE = 4'h8
  } acs_state_type;

  typedef struct packed {
    logic       powered;  // Analog bias on
    logic       sample;   // Hold capacitor tied to the selected pin
    logic [1:0] channel;  // Selected input, 3 means pin four
    logic       ref_pin;  // Reference from pin one, else supply
    logic [7:0] trial;    // Successive approximation code to the DAC
  } acs_ana_type;

endpackage

// ==== logic/acs_seq.sv ====
// Converter sequencer, port configuration and AXI4-Lite register slave.
// Assumes a comparator outside that reports the held sample against trial.
//
// Summary of operation
// - Clock select picks bit period source
// - Channel select routes one of four pins
// - Go flag starts, shows, self-clears conversion
// - Converter-on bit powers converter up or down
// - Completion loads result, clears go, sets done
// - Eight-bit result by successive approximation
// - Port config code assigns analog and digital pins
// - Analog pins read as zero on port
// - Reset makes all pins analog, controls zero
// - Port config write may raise pin flags
// - Two bit periods before next acquisition
// - Conversion continues in sleep with RC clock
// - Conversion lasts nine and a half periods
// - Clearing go aborts, result kept unchanged
// - After abort wait two periods, then acquire
`timescale 1ns/100ps
module acs_seq (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // AXI4-Lite write address and data
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  // AXI4-Lite write response
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  output logic [1:0]              s_axi_bresp,
  // AXI4-Lite read
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  input  wire logic [11:0]        s_axi_araddr,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  // Device environment
  input  wire logic               sleep_mode,
  input  wire logic               rc_half_tick,
  input  wire logic               cmp_above,
  input  wire logic [3:0]         pin_level,
  // Analog side and flags
  output acs_pkg::acs_ana_type    ana,
  output logic [3:0]              pin_analog,
  output logic                    cfg_wr_pulse,
  output logic                    conv_done
);

  acs_pkg::acs_state_type state_q;
  acs_pkg::acs_state_type state_d;

  logic        aw_hold_q;
  logic [9:0]  aw_idx_q;
  logic        w_hold_q;
  logic [7:0]  w_byte_q;
  logic        w_lane_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        wr_fire;
  logic        wr_ctl;
  logic        wr_cfg;
  logic        wr_res;
  logic        wr_stat;
  logic        aw_mapped;
  logic        ar_take;
  logic [7:0]  rd_byte;
  logic        rd_mapped;

  logic [7:0]  ctl_q;
  logic        go_q;
  logic [2:0]  pcfg_q;
  logic [3:0]  analog_q;
  logic        ref_pin_q;
  logic [7:0]  result_q;
  logic        done_q;
  logic        cfg_pulse_q;
  logic [7:0]  trial_q;
  logic [4:0]  hcnt_q;
  logic [1:0]  scnt_q;
  logic        half_tick;
  logic        start;
  logic        abort;
  logic        complete;
  logic        settle_end;
  logic [2:0]  bpos;
  logic [7:0]  port_view;

  // =========================================================
  // Bit period strobes
  acs_tad_gen u_tad (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .run          (ctl_q[acs_pkg::CTL_ON_BIT]),
    .sleep_mode   (sleep_mode),
    .clk_sel      (ctl_q[acs_pkg::CTL_CLK_LSB +: 2]),
    .rc_half_tick (rc_half_tick),
    .half_tick    (half_tick)
  );

  // =========================================================
  // AXI4-Lite write path: address and data held until both are in
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_hold_q && w_hold_q;
  assign aw_mapped     = (aw_idx_q == acs_pkg::IDX_CTL) || (aw_idx_q == acs_pkg::IDX_CFG)
                      || (aw_idx_q == acs_pkg::IDX_RESULT) || (aw_idx_q == acs_pkg::IDX_STAT)
                      || (aw_idx_q == acs_pkg::IDX_PORT);
  // Registers live in byte lane 0 only
  assign wr_ctl  = wr_fire && w_lane_q && (aw_idx_q == acs_pkg::IDX_CTL);
  assign wr_cfg  = wr_fire && w_lane_q && (aw_idx_q == acs_pkg::IDX_CFG);
  assign wr_res  = wr_fire && w_lane_q && (aw_idx_q == acs_pkg::IDX_RESULT);
  assign wr_stat = wr_fire && w_lane_q && (aw_idx_q == acs_pkg::IDX_STAT);

  // Write address capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_hold_q <= 1'b0;
      aw_idx_q  <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[11:2];
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      w_hold_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_byte_q <= s_axi_wdata[7:0];
      w_lane_q <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  // Write response, error for an unmapped word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= acs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= aw_mapped ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // =========================================================
  // AXI4-Lite read path, answer one cycle after the address
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign ar_take       = s_axi_arvalid && !rvalid_q;

  assign port_view = {3'h0, pin_level[3] & ~analog_q[3], 1'b0,
                      pin_level[2:0] & ~analog_q[2:0]};

  // Read multiplexer; go reads back the live conversion state
  always_comb begin
    rd_byte   = 8'h00;
    rd_mapped = 1'b1;
    case (s_axi_araddr[11:2])
      acs_pkg::IDX_CTL:    rd_byte = {ctl_q[7:3], go_q, ctl_q[1:0]};
      acs_pkg::IDX_CFG:    rd_byte = {5'h00, pcfg_q};
      acs_pkg::IDX_RESULT: rd_byte = result_q;
      acs_pkg::IDX_STAT:   rd_byte = {7'h00, done_q};
      acs_pkg::IDX_PORT:   rd_byte = port_view;
      default:             rd_mapped = 1'b0;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= acs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_mapped ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // =========================================================
  // Control register; go lives apart because hardware clears it
  // controls reset to zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= acs_pkg::CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= w_byte_q & 8'hFB;
    end
  end

  // Go takes effect only when the converter was already on and idle,
  // so a write that turns the converter on cannot also start it
  // go ignored while off
  assign start = wr_ctl && w_byte_q[acs_pkg::CTL_GO_BIT] && ctl_q[acs_pkg::CTL_ON_BIT]
              && w_byte_q[acs_pkg::CTL_ON_BIT] && (state_q == acs_pkg::ST_ACQ);
  // clearing go aborts; turning off aborts too, so go never outlives power
  assign abort = wr_ctl && (!w_byte_q[acs_pkg::CTL_GO_BIT] || !w_byte_q[acs_pkg::CTL_ON_BIT])
              && (state_q == acs_pkg::ST_CONV);
  assign complete   = (state_q == acs_pkg::ST_CONV) && half_tick
                   && (hcnt_q == acs_pkg::CONV_LAST) && !abort;
  assign settle_end = (state_q == acs_pkg::ST_SETTLE) && half_tick
                   && (scnt_q == acs_pkg::SETTLE_LAST);

  // Go flag: set by software, cleared by completion, abort or power-off
  // go set and self-clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      go_q <= 1'b0;
    end else if (start) begin
      go_q <= 1'b1;
    end else if (complete || abort || !ctl_q[acs_pkg::CTL_ON_BIT]) begin
      go_q <= 1'b0;
    end
  end

  // =========================================================
  // Sequencer state
  // off forces shutdown
  always_comb begin
    state_d = state_q;
    case (state_q)
      acs_pkg::ST_OFF:    state_d = acs_pkg::ST_ACQ;
      acs_pkg::ST_ACQ:    if (start) state_d = acs_pkg::ST_CONV;
      acs_pkg::ST_CONV:   if (complete || abort) state_d = acs_pkg::ST_SETTLE;
      acs_pkg::ST_SETTLE: if (settle_end) state_d = acs_pkg::ST_ACQ;
      default:            state_d = acs_pkg::ST_OFF;
    endcase
    if (!ctl_q[acs_pkg::CTL_ON_BIT]) begin
      state_d = acs_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= acs_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Half period counters for conversion and settling
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hcnt_q <= 5'h00;
      scnt_q <= 2'h0;
    end else begin
      if (state_q != acs_pkg::ST_CONV) begin
        hcnt_q <= 5'h00;
      end else if (half_tick) begin
        hcnt_q <= hcnt_q + 5'h01;
      end
      if (state_q != acs_pkg::ST_SETTLE) begin
        scnt_q <= 2'h0;
      end else if (half_tick) begin
        scnt_q <= scnt_q + 2'h1;
      end
    end
  end

  // =========================================================
  // Successive approximation: one bit decided every second half period
  assign bpos = 3'h7 - hcnt_q[3:1];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trial_q <= 8'h80;
    end else if (start) begin
      trial_q <= 8'h80;
    end else if ((state_q == acs_pkg::ST_CONV) && half_tick && hcnt_q[0]
                 && (hcnt_q <= acs_pkg::DECIDE_LAST)) begin
      for (int i = 0; i < 8; i++) begin
        if (i == int'(bpos)) begin
          trial_q[i] <= cmp_above;
        end else if (i + 1 == int'(bpos)) begin
          trial_q[i] <= 1'b1;
        end
      end
    end
  end

  // Result: completion wins over a software write in the same cycle
  // result load
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result_q <= acs_pkg::RESULT_RST;
    end else if (complete) begin
      result_q <= trial_q;
    end else if (wr_res) begin
      result_q <= w_byte_q;
    end
  end

  // Done flag: sticky, write one to clear, a new event wins the race
  // done flag set
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else if (complete) begin
      done_q <= 1'b1;
    end else if (wr_stat && w_byte_q[acs_pkg::STAT_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // =========================================================
  // Port configuration; decoded at write time so outputs are flops
  // pin assignment
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pcfg_q    <= acs_pkg::CFG_RST;
      analog_q  <= 4'hF;
      ref_pin_q <= 1'b0;
    end else if (wr_cfg) begin
      pcfg_q    <= w_byte_q[2:0];
      ref_pin_q <= w_byte_q[0] && (w_byte_q[2:0] != 3'h7);
      case (w_byte_q[2:1])
        2'h0:    analog_q <= 4'hF;
        2'h1:    analog_q <= 4'h7;
        2'h2:    analog_q <= 4'h3;
        default: analog_q <= w_byte_q[0] ? 4'h0 : 4'h1;
      endcase
    end
  end

  // Pin function changes can glitch the pin-change logic outside
  // config write pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_pulse_q <= 1'b0;
    end else begin
      cfg_pulse_q <= wr_cfg;
    end
  end

  // =========================================================
  // Outputs to the analog side
  // channel routing
  assign ana.powered = ctl_q[acs_pkg::CTL_ON_BIT];
  assign ana.sample  = (state_q == acs_pkg::ST_ACQ);
  assign ana.channel = ctl_q[acs_pkg::CTL_CHS_LSB +: 2];
  assign ana.ref_pin = ref_pin_q;
  assign ana.trial   = trial_q;
  assign pin_analog   = analog_q;
  assign cfg_wr_pulse = cfg_pulse_q;
  assign conv_done    = done_q;

  // =========================================================
  // Checks
  property p_go_needs_on;
    @(posedge clk_sys) disable iff (!rstn)
    go_q |-> ctl_q[acs_pkg::CTL_ON_BIT] && (state_q == acs_pkg::ST_CONV);
  endproperty
  a_go_needs_on: assert property (p_go_needs_on) else $error("Go set while not converting");

  property p_complete;
    @(posedge clk_sys) disable iff (!rstn)
    complete |=> !go_q && done_q && (result_q == $past(trial_q))
                 && (state_q == acs_pkg::ST_SETTLE);
  endproperty
  a_complete: assert property (p_complete) else $error("Completion event incomplete");

  property p_abort_keeps;
    @(posedge clk_sys) disable iff (!rstn)
    abort |=> !go_q && $stable(done_q) && $stable(result_q);
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("Abort changed the result");

  property p_len;
    @(posedge clk_sys) disable iff (!rstn)
    ($fell(go_q) && $past(state_q == acs_pkg::ST_CONV) && !$past(abort)
     && $past(ctl_q[acs_pkg::CTL_ON_BIT])) |-> $past(hcnt_q) == 5'h12;
  endproperty
  a_len: assert property (p_len) else $error("Conversion not 19 half periods");

  property p_settle;
    @(posedge clk_sys) disable iff (!rstn)
    (state_q == acs_pkg::ST_CONV && state_d == acs_pkg::ST_SETTLE)
      |=> !ana.sample && (state_q == acs_pkg::ST_SETTLE) && (scnt_q == 2'h0);
  endproperty
  a_settle: assert property (p_settle) else $error("Settle wait skipped");

  property p_reacquire;
    @(posedge clk_sys) disable iff (!rstn)
    settle_end && ctl_q[acs_pkg::CTL_ON_BIT] |=> ana.sample;
  endproperty
  a_reacquire: assert property (p_reacquire) else $error("No acquisition after settle");

  property p_off_ignores;
    @(posedge clk_sys) disable iff (!rstn)
    (wr_ctl && !ctl_q[acs_pkg::CTL_ON_BIT]) |=> !go_q;
  endproperty
  a_off_ignores: assert property (p_off_ignores) else $error("Go accepted while off");

  property p_port_zero;
    @(posedge clk_sys) disable iff (!rstn)
    ({port_view[4], port_view[2:0]} & analog_q) == 4'h0;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("Analog pin read nonzero");

  property p_ref;
    @(posedge clk_sys) disable iff (!rstn)
    ana.ref_pin == ((pcfg_q == 3'h1) || (pcfg_q == 3'h3) || (pcfg_q == 3'h5));
  endproperty
  a_ref: assert property (p_ref) else $error("Reference select wrong");

  c_complete: cover property (@(posedge clk_sys) disable iff (!rstn) complete);
  c_abort:    cover property (@(posedge clk_sys) disable iff (!rstn) abort);
  c_race:     cover property (@(posedge clk_sys) disable iff (!rstn) complete && wr_stat);

endmodule

// ==== logic/acs_tad_gen.sv ====
// Half bit-period strobe generator for the converter.
// Assumes rc_half_tick is a one-cycle pulse synchronous to clk_sys.
`timescale 1ns/100ps
module acs_tad_gen (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Control
  input  wire logic       run,
  input  wire logic       sleep_mode,
  input  wire logic [1:0] clk_sel,
  input  wire logic       rc_half_tick,
  // Strobe
  output logic            half_tick
);

  logic [3:0] div_cnt_q;
  logic [3:0] div_last;
  logic       osc_tick;

  // =========================================================
  // Divider selection
  // clock select decode
  always_comb begin
    case (clk_sel)
      2'h0:    div_last = acs_pkg::DIV2_LAST;
      2'h1:    div_last = acs_pkg::DIV8_LAST;
      2'h2:    div_last = acs_pkg::DIV32_LAST;
      default: div_last = acs_pkg::DIV2_LAST;
    endcase
  end

  // The oscillator stops in sleep; only the RC source keeps ticking
  // sleep clock gating
  assign osc_tick  = run && !sleep_mode && (div_cnt_q == div_last);
  assign half_tick = (clk_sel == acs_pkg::CLK_SEL_RC) ? (run && rc_half_tick) : osc_tick;

  // Divider counter restarts whenever the converter is off or in sleep
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= 4'h0;
    end else if (!run || sleep_mode || div_cnt_q == div_last) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // =========================================================
  // Checks
  property p_div8_gap;
    @(posedge clk_sys) disable iff (!rstn)
    (half_tick && clk_sel == 2'h1 && $stable(clk_sel)) |=> !half_tick [*3];
  endproperty
  a_div8_gap: assert property (p_div8_gap) else $error("Divide-by-8 strobe too close");

endmodule

// ==== tb/acs_ana_src.sv ====
// Analog sources on the port pins, with the hold capacitor and comparator.
// Assumes ana comes from acs_seq; vin holds four 8-bit levels, channel 0 lowest.
`timescale 1ns/100ps
module acs_ana_src (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Converter side
  input  wire acs_pkg::acs_ana_type ana,
  input  wire logic [31:0]          vin,
  output logic                      cmp_above
);
  // ==========================================================
  // Hold capacitor and comparator
  logic [7:0] held_q;
  logic       tog_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      held_q <= 8'h00;
    end else if (ana.powered && ana.sample) begin
      held_q <= vin[{ana.channel, 3'h0} +: 8];
    end
  end
  // Unpowered comparator gives noise, so a sequencer leaning on it is caught
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
    end
  end
  assign cmp_above = ana.powered ? (held_q >= ana.trial) : tog_q;
endmodule

// ==== tb/tb_acs_seq.sv ====
// Register-level bench for the converter sequencer.
// Assumes acs_seq at 250 MHz with the analog source model beside it.
`timescale 1ns/100ps
module tb_acs_seq;
  // ==========================================================
  // Signals
  logic        clk_sys = 1'b0, rstn = 1'b0, sleep_mode = 1'b0, rc_tick = 1'b0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, cmp, cfg_pulse, conv_done;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  pin_analog, pa;
  logic [7:0]  v;
  logic [3:0]  pa_tab [8] = '{4'hF, 4'hF, 4'h7, 4'h7, 4'h3, 4'h3, 4'h1, 4'h0};
  logic [31:0] vin = 32'hFF01_5AC3;
  int          bad_count = 0, num_checks = 0, pulses = 0, rc_cnt = 0, i;
  acs_pkg::acs_ana_type ana;

  // ==========================================================
  // Clock, RC half ticks every third cycle, config pulse counter
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rc_cnt  <= (rc_cnt == 2) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == 2);
    if (cfg_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  acs_seq i_dut (
    .clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .sleep_mode(sleep_mode), .rc_half_tick(rc_tick), .cmp_above(cmp), .pin_level(4'hF),
    .ana(ana), .pin_analog(pin_analog), .cfg_wr_pulse(cfg_pulse), .conv_done(conv_done)
  );
  acs_ana_src i_src (.clk_sys(clk_sys), .rstn(rstn), .ana(ana), .vin(vin), .cmp_above(cmp));

  // ==========================================================
  // Checks, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Every wait is bounded; a hang ends the run as a mismatch
  task automatic hang(inout int n);
    n++;
    if (n > 2000) begin
      bad_count++;
      $display("MISMATCH t=%0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] val,
                    input logic [1:0] er = acs_pkg::RESP_OKAY);
    int   n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      hang(n);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    // Ready raised only after the take, so back-to-back calls never clash on it
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      hang(n);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [9:0] idx);
    int n;
    n = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      hang(n);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      hang(n);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [7:0] e);
    rd(idx);
    chk(d, {24'h0, e});
    chk(resp, acs_pkg::RESP_OKAY);
  endtask
  // Software waits for the go flag to drop
  task automatic poll();
    int n;
    n = 0;
    do begin
      rd(acs_pkg::IDX_CTL);
      hang(n);
    end while (d[2] !== 1'b0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rchk(acs_pkg::IDX_CTL, 8'h00);
    rchk(acs_pkg::IDX_CFG, 8'h00);
    chk(pin_analog, 4'hF);
    rchk(acs_pkg::IDX_PORT, 8'h00);
    wr(acs_pkg::IDX_CTL, 8'h26);
    rchk(acs_pkg::IDX_CTL, 8'h22);
    chk(ana.powered, 1'b0);
    wr(10'h3FF, 8'h11, acs_pkg::RESP_SLVERR);
    rd(10'h3FF);
    chk(resp, acs_pkg::RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      wr(acs_pkg::IDX_CFG, i[7:0]);
      pa = pa_tab[i];
      chk(pin_analog, pa);
      chk(ana.ref_pin, (i % 2 == 1) && (i < 7));
      rchk(acs_pkg::IDX_PORT, {3'h0, ~pa[3], 1'b0, ~pa[2:0]});
    end
    chk(pulses, 8);
    wr(acs_pkg::IDX_CFG, 8'h00);
    // Every clock select, each on its own channel; the RC one runs in sleep
    for (i = 0; i < 4; i++) begin
      sleep_mode <= (i == 3);
      v = {i[1:0], 1'b0, i[1:0], 3'b001};
      wr(acs_pkg::IDX_CTL, v);
      repeat (200) @(posedge clk_sys);
      wr(acs_pkg::IDX_CTL, v | 8'h04);
      if (i == 2) begin
        repeat (200) @(posedge clk_sys);
        rchk(acs_pkg::IDX_CTL, v | 8'h04);
      end
      poll();
      rchk(acs_pkg::IDX_RESULT, vin[8*i +: 8]);
      chk(conv_done, 1'b1);
      wr(acs_pkg::IDX_STAT, 8'h01);
      rchk(acs_pkg::IDX_STAT, 8'h00);
    end
    sleep_mode <= 1'b0;
    wr(acs_pkg::IDX_RESULT, 8'hA5);
    wr(acs_pkg::IDX_CTL, 8'h89);
    repeat (200) @(posedge clk_sys);
    wr(acs_pkg::IDX_CTL, 8'h8D);
    repeat (60) @(posedge clk_sys);
    wr(acs_pkg::IDX_CTL, 8'h89);
    repeat (400) @(posedge clk_sys);
    rchk(acs_pkg::IDX_RESULT, 8'hA5);
    chk(conv_done, 1'b0);
    wr(acs_pkg::IDX_CTL, 8'h8D);
    poll();
    rchk(acs_pkg::IDX_RESULT, 8'h5A);
    wr(acs_pkg::IDX_CTL, 8'h00);
    chk(ana.powered, 1'b0);
    tally_and_finish();
  end
endmodule
